/* File: psi_pkg.sv */
// Function
// - Reset samples duplex pin into control bit 8
// - Reset samples activity pin into bit 12
// - Duplex pin drives active low after sampling
// - Activity pin active low, function set by 1eh
// - Speed pin: speed, or 100M link
// - Modes 00/10: duplex pin low when full
// - Mode 01: duplex level, blinks on collision
// - Mode 00: activity pin low on collision
// - Modes 01/10: activity pin blinks on traffic
// - Power-down input active low, low powers down
// - Indicator mode writable by software at 1eh
//
// Purpose: Constants shared by the status indicator block.
// Assumes: 10 MHz system clock, 16-bit register port.
// Notes:   Register offsets are byte-free indices on the plain port.
package psi_pkg;

   // Clock
   localparam int CLK_PERIOD_NS = 100;

   // Register port
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_MODE = 5'h1E;
   localparam logic [4:0] REG_STATUS = 5'h1F;

   // Control register fields
   localparam int CTRL_DUPLEX_BIT = 8;
   localparam int CTRL_ANEG_BIT = 12;

   // Mode register field
   localparam int MODE_LSB = 0;
   localparam logic [1:0] MODE_RST = 2'h0;

   // Status register fields
   localparam int STAT_RUN_BIT = 0;
   localparam int STAT_PD_BIT = 1;
   localparam int STAT_LINK_BIT = 2;
   localparam int STAT_SPEED_BIT = 3;
   localparam int STAT_FULL_BIT = 4;
   localparam int STAT_COL_BIT = 5;
   localparam int STAT_ACT_BIT = 6;
   localparam int STAT_BLINK_BIT = 7;

   // Indicator modes
   localparam logic [1:0] MODE_00 = 2'h0;
   localparam logic [1:0] MODE_01 = 2'h1;
   localparam logic [1:0] MODE_10 = 2'h2;
   localparam logic [1:0] MODE_11 = 2'h3;

   // Strap window after reset release
   localparam int STRAP_TIME_NS = 2000;
   localparam int STRAP_CYCLES = (STRAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STRAP_CNT_W = 8;

   // Blink half period
   localparam int BLINK_HALF_US = 50000;
   localparam int BLINK_CYCLES = (BLINK_HALF_US * 1000) / CLK_PERIOD_NS;

   // Controller states
   typedef enum logic {
      PSI_ST_STRAP,
      PSI_ST_RUN
   } psi_state_e;

endpackage : psi_pkg

/* File: psi_sync.sv */
// Purpose: Two-stage synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to clk_sys.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/100ps
module psi_sync #(
   parameter int WIDTH = 1,
   // Idle level of each pin, so leaving reset shows no false change
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Data
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } psi_sync_s;

   psi_sync_s r;
   psi_sync_s next_r;

   // First stage feeds only the second stage
   always_comb begin
      next_r.meta = d;
      next_r.stable = r.meta;
   end

   // State register
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         r <= {RST_VAL, RST_VAL};
      end else begin
         r <= next_r;
      end
   end

   assign q = r.stable;

endmodule // psi_sync

/* File: psi_indicators.sv */
// Purpose: Status indicator outputs with strap capture at reset.
// Assumes: Link status inputs come from logic on clk_sys; pins and
//          the power-down input are asynchronous.
// Notes:   Indicator pins are released during the strap window so
//          board resistors set their level; they drive afterwards.
`timescale 1ns/100ps
module psi_indicators
   import psi_pkg::*;
#(
   parameter int BLINK_HALF_CYCLES = BLINK_CYCLES
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [DATA_W-1:0] rd_data,
   // Link status from the transceiver core
   input wire logic link_up,
   input wire logic hundred_mbit_speed,
   input wire logic full_duplex,
   input wire logic collision,
   input wire logic activity,
   // Power-down pin
   input wire logic power_down_n,
   // Speed indicator pin
   output logic speed_indicator_out,
   output logic speed_indicator_oe,
   // Duplex indicator pin, also strap
   input wire logic duplex_indicator_in,
   output logic duplex_indicator_out,
   output logic duplex_indicator_oe,
   // Collision/activity indicator pin, also autoneg strap
   input wire logic collision_activity_indicator_in,
   output logic collision_activity_indicator_out,
   output logic collision_activity_indicator_oe,
   // Control outputs to the core
   output logic duplex_select,
   output logic autoneg_enable_bit,
   output logic power_down
);

   localparam int CNT_W = $clog2(BLINK_HALF_CYCLES + 1);

   typedef struct packed {
      psi_state_e state;
      logic [STRAP_CNT_W-1:0] strap_cnt;
      logic [CNT_W-1:0] blink_cnt;
      logic blink_phase;
      logic [1:0] indicator_mode_select;
      logic duplex_select;
      logic autoneg_enable_bit;
      logic power_down;
      logic [DATA_W-1:0] rd_data;
      logic spd_out;
      logic dup_out;
      logic ca_out;
      logic pins_oe;
   } psi_state_s;

   psi_state_s r;
   psi_state_s next_r;

   // Synchronised pin levels
   logic [2:0] pin_sync;
   logic dup_strap;
   logic ca_strap;
   logic pd_n_sync;

   // Reserved mode falls back to the plain mode
   function automatic logic [1:0] psi_eff_mode(input logic [1:0] m);
      psi_eff_mode = (m == MODE_11) ? MODE_00 : m;
   endfunction

   // Strap pins and power-down arrive from outside the clock domain
   // Power-down pin idles high: a zero reset value would fake a power-down pulse
   psi_sync #(
      .WIDTH(3),
      .RST_VAL(3'h4)
   ) i_psi_sync (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .d({power_down_n, collision_activity_indicator_in, duplex_indicator_in}),
      .q(pin_sync)
   );

   assign dup_strap = pin_sync[0];
   assign ca_strap = pin_sync[1];
   assign pd_n_sync = pin_sync[2];

   // Next-state logic
   always_comb begin
      logic [1:0] eff;
      logic [DATA_W-1:0] rd_word;
      eff = psi_eff_mode(r.indicator_mode_select);
      rd_word = '0;
      next_r = r;

      // Free-running blink timer; slow enough to see, one rate for all
      if (r.blink_cnt == CNT_W'(BLINK_HALF_CYCLES - 1)) begin
         next_r.blink_cnt = '0;
         next_r.blink_phase = ~r.blink_phase;
      end else begin
         next_r.blink_cnt = r.blink_cnt + CNT_W'(1);
      end

      // Low level on the pin requests power down
      next_r.power_down = ~pd_n_sync;

      // Register writes
      if (wr_en) begin
         if (addr == REG_CTRL) begin
            next_r.duplex_select = wr_data[CTRL_DUPLEX_BIT];
            next_r.autoneg_enable_bit = wr_data[CTRL_ANEG_BIT];
         end else if (addr == REG_MODE) begin
            next_r.indicator_mode_select = wr_data[MODE_LSB +: 2];
         end
      end

      // Register reads; data stands only in the following cycle
      case (addr)
         REG_CTRL: begin
            rd_word[CTRL_DUPLEX_BIT] = r.duplex_select;
            rd_word[CTRL_ANEG_BIT] = r.autoneg_enable_bit;
         end
         REG_MODE: begin
            rd_word[MODE_LSB +: 2] = r.indicator_mode_select;
         end
         REG_STATUS: begin
            rd_word[STAT_RUN_BIT] = (r.state == PSI_ST_RUN);
            rd_word[STAT_PD_BIT] = r.power_down;
            rd_word[STAT_LINK_BIT] = link_up;
            rd_word[STAT_SPEED_BIT] = hundred_mbit_speed;
            rd_word[STAT_FULL_BIT] = full_duplex;
            rd_word[STAT_COL_BIT] = collision;
            rd_word[STAT_ACT_BIT] = activity;
            rd_word[STAT_BLINK_BIT] = r.blink_phase;
         end
         default: begin
            rd_word = '0;
         end
      endcase
      next_r.rd_data = rd_en ? rd_word : '0;

      // Pin sequencing
      case (r.state)
         PSI_ST_STRAP: begin
            // Pins float so the strap resistors set their level
            next_r.pins_oe = 1'b0;
            next_r.spd_out = 1'b1;
            next_r.dup_out = 1'b1;
            next_r.ca_out = 1'b1;
            next_r.strap_cnt = r.strap_cnt + STRAP_CNT_W'(1);
            if (r.strap_cnt == STRAP_CNT_W'(STRAP_CYCLES - 1)) begin
               // Strap wins over a write landing in the same cycle
               next_r.duplex_select = dup_strap;
               next_r.autoneg_enable_bit = ca_strap;
               next_r.state = PSI_ST_RUN;
               next_r.pins_oe = 1'b1;
            end
         end
         PSI_ST_RUN: begin
            next_r.pins_oe = 1'b1;
            // Speed pin
            if (eff == MODE_10) begin
               next_r.spd_out = ~(link_up & hundred_mbit_speed);
            end else begin
               next_r.spd_out = ~hundred_mbit_speed;
            end
            // Duplex pin: lit when full duplex
            if (eff == MODE_01) begin
               next_r.dup_out = ~full_duplex ^ (collision & r.blink_phase);
            end else begin
               next_r.dup_out = ~full_duplex;
            end
            // Collision/activity pin
            if (eff == MODE_00) begin
               next_r.ca_out = ~collision;
            end else begin
               next_r.ca_out = activity ? r.blink_phase : 1'b1;
            end
            // All lamps dark while powered down
            if (r.power_down) begin
               next_r.spd_out = 1'b1;
               next_r.dup_out = 1'b1;
               next_r.ca_out = 1'b1;
            end
         end
         default: begin
            next_r.state = PSI_ST_STRAP;
            next_r.strap_cnt = '0;
            next_r.pins_oe = 1'b0;
         end
      endcase
   end

   // State register; constants only under reset
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         r <= '0;
         r.state <= PSI_ST_STRAP;
         r.indicator_mode_select <= MODE_RST;
         r.spd_out <= 1'b1;
         r.dup_out <= 1'b1;
         r.ca_out <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // Outputs come straight from the state register
   assign rd_data = r.rd_data;
   assign speed_indicator_out = r.spd_out;
   assign speed_indicator_oe = r.pins_oe;
   assign duplex_indicator_out = r.dup_out;
   assign duplex_indicator_oe = r.pins_oe;
   assign collision_activity_indicator_out = r.ca_out;
   assign collision_activity_indicator_oe = r.pins_oe;
   assign duplex_select = r.duplex_select;
   assign autoneg_enable_bit = r.autoneg_enable_bit;
   assign power_down = r.power_down;

endmodule // psi_indicators

/* File: psi_lamps.sv */
// Purpose: Board side of one indicator pin: lamp plus strap resistor.
// Assumes: The resistor sets the pin level whenever the pin is released.
// Notes: Lamp state is not modelled, only the pin level.
`timescale 1ns/100ps
module psi_lamps #(
   parameter logic STRAP = 1'h1
) (
   // Driver side
   input wire logic out,
   input wire logic oe,
   // Pin level
   output logic pin
);
   // A released pin falls to the resistor level, never the last driven one
   assign pin = oe ? out : STRAP;
endmodule // psi_lamps

/* File: psi_assertions.sv */
// Purpose: Port checks of the status indicator block.
// Assumes: Mode is mirrored from the write port.
// Notes: Output checks skip power down, which forces lamps off.
`timescale 1ns/100ps
module psi_assertions
   import psi_pkg::*;
#(
   parameter int BLINK_HALF_CYCLES = BLINK_CYCLES
) (
   // Clock, reset, register port
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [DATA_W-1:0] rd_data,
   // Status, pins, control
   input wire logic link_up,
   input wire logic hundred_mbit_speed,
   input wire logic full_duplex,
   input wire logic collision,
   input wire logic activity,
   input wire logic power_down_n,
   input wire logic speed_indicator_out,
   input wire logic speed_indicator_oe,
   input wire logic duplex_indicator_in,
   input wire logic duplex_indicator_out,
   input wire logic duplex_indicator_oe,
   input wire logic collision_activity_indicator_in,
   input wire logic collision_activity_indicator_out,
   input wire logic collision_activity_indicator_oe,
   input wire logic duplex_select,
   input wire logic autoneg_enable_bit,
   input wire logic power_down
);
   logic [1:0] mode;
   logic [4:0] cnt;
   logic ok;
   int run;
   // Mode mirror, cycles since release, length of a steady blink level
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         mode <= MODE_00;
         cnt <= 5'h00;
         ok <= 1'h0;
         run <= 0;
      end else begin
         if (wr_en && addr == REG_MODE) mode <= wr_data[1:0];
         if (cnt != 5'h1F) cnt <= cnt + 5'h01;
         ok <= cnt >= STRAP_CYCLES && !power_down;
         run <= (ok && !power_down && $past(mode[0] ^ mode[1]) && $past(activity) &&
            collision_activity_indicator_out == $past(collision_activity_indicator_out))
            ? run + 1 : 0;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   AST_STRAP_DUP: assert property ($rose(duplex_indicator_oe) |->
      duplex_select == $past(duplex_indicator_in)) else $error("duplex strap lost");
   AST_STRAP_ANEG: assert property ($rose(collision_activity_indicator_oe) |->
      autoneg_enable_bit == $past(collision_activity_indicator_in)) else $error("aneg strap");
   AST_WINDOW: assert property ({speed_indicator_oe, duplex_indicator_oe,
      collision_activity_indicator_oe} == {3{cnt >= STRAP_CYCLES}})
      else $error("pin drive window wrong");
   AST_SPEED: assert property (ok && !power_down |-> speed_indicator_out ==
      !($past(hundred_mbit_speed) && ($past(link_up) || $past(mode) != MODE_10)))
      else $error("speed lamp wrong");
   AST_DUPLEX: assert property (ok && !power_down &&
      ($past(mode) != MODE_01 || !$past(collision)) |-> duplex_indicator_out == !$past(full_duplex))
      else $error("duplex lamp wrong");
   AST_COL: assert property (ok && !power_down && !$past(mode[0] ^ mode[1]) |->
      collision_activity_indicator_out == !$past(collision)) else $error("collision lamp wrong");
   AST_BLINK: assert property (run <= BLINK_HALF_CYCLES) else $error("blink too slow");
   AST_PD_FOLLOW: assert property (cnt >= 5'h03 |->
      power_down == !$past(power_down_n, 3)) else $error("power down late");
   AST_PD_DARK: assert property (power_down && $past(power_down) |->
      speed_indicator_out && duplex_indicator_out && collision_activity_indicator_out)
      else $error("lamp lit in power down");
   AST_READ_MODE: assert property (rd_en && addr == REG_MODE |=>
      rd_data == {14'h0000, $past(mode)}) else $error("mode readback wrong");
endmodule // psi_assertions
bind psi_indicators psi_assertions #(.BLINK_HALF_CYCLES(BLINK_HALF_CYCLES))
   i_psi_assertions (.*);

/* File: psi_indicators_tb.sv */
// Purpose: Self-checking bench for the status indicator block.
// Assumes: Board straps pull duplex low and autoneg high.
// Notes: A short blink period keeps the run brief.
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
   $display("unexpected at %0t got %h want %h", $time, a, b); end end
module psi_indicators_tb;
   import psi_pkg::*;
   localparam int BH = 4;
   logic clk_sys, nrst, wr_en, rd_en, link_up, hundred_mbit_speed, full_duplex, collision;
   logic activity, power_down_n, speed_indicator_out, speed_indicator_oe, duplex_indicator_in;
   logic duplex_indicator_out, duplex_indicator_oe, collision_activity_indicator_in;
   logic collision_activity_indicator_out, collision_activity_indicator_oe;
   logic duplex_select, autoneg_enable_bit, power_down;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wr_data, rd_data, got;
   int num_errors, checked;
   psi_indicators #(.BLINK_HALF_CYCLES(BH)) i_psi_indicators (.*);
   psi_lamps #(.STRAP(1'h0)) i_psi_lamps_dup (.out(duplex_indicator_out),
      .oe(duplex_indicator_oe), .pin(duplex_indicator_in));
   psi_lamps #(.STRAP(1'h1)) i_psi_lamps_col (.out(collision_activity_indicator_out),
      .oe(collision_activity_indicator_oe), .pin(collision_activity_indicator_in));
   // Register port cycles; each starts on a fresh edge so strobes never clash
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_sys);
      {addr, wr_data, wr_en} <= {a, d, 1'h1};
      @(posedge clk_sys);
      wr_en <= 1'h0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a);
      @(posedge clk_sys);
      {addr, rd_en} <= {a, 1'h1};
      @(posedge clk_sys);
      rd_en <= 1'h0;
      #1 got = rd_data;
   endtask
   // Straps, drive after the window, unmapped read
   task automatic t_strap;
      `CHK({duplex_select, autoneg_enable_bit}, 2'h1)
      `CHK({speed_indicator_oe, duplex_indicator_oe, collision_activity_indicator_oe}, 3'h7)
      rd(REG_CTRL);
      `CHK(got, 16'h0001 << CTRL_ANEG_BIT)
      rd(5'h05);
      `CHK(got, 16'h0000)
      wr(REG_CTRL, 16'h0100);
      rd(REG_CTRL);
      `CHK(got, 16'h0100)
      `CHK({duplex_select, autoneg_enable_bit}, 2'h2)
   endtask
   // Every mode, 11 must look like 00
   task automatic t_modes;
      for (int m = 0; m < 4; m++) begin
         @(posedge clk_sys);
         collision <= (m != 1);
         wr(REG_MODE, 16'(m));
         repeat (2) @(posedge clk_sys);
         #1 `CHK(speed_indicator_out, m == 2)
         `CHK(duplex_indicator_out, 1'h0)
         `CHK(collision_activity_indicator_out, m == 1 || m == 2)
         rd(REG_MODE);
         `CHK(got, 16'(m))
      end
      @(posedge clk_sys);
      link_up <= 1'h1;
      wr(REG_MODE, 16'h0002);
      repeat (2) @(posedge clk_sys);
      #1 `CHK(speed_indicator_out, 1'h0)
      // 10 Mbit/s half duplex: lamps dark in modes 10 and 01
      @(posedge clk_sys);
      {hundred_mbit_speed, full_duplex} <= 2'h0;
      repeat (2) @(posedge clk_sys);
      #1 `CHK(speed_indicator_out, 1'h1)
      `CHK(duplex_indicator_out, 1'h1)
      @(posedge clk_sys);
      collision <= 1'h0;
      wr(REG_MODE, 16'h0001);
      repeat (2) @(posedge clk_sys);
      #1 `CHK(speed_indicator_out, 1'h1)
      `CHK(duplex_indicator_out, 1'h1)
   endtask
   // Blink count over ten half periods in mode 01
   task automatic t_blink;
      int tc, td;
      logic pc, pw;
      {tc, td} = 0;
      @(posedge clk_sys);
      {collision, activity, hundred_mbit_speed, full_duplex} <= 4'hF;
      wr(REG_MODE, 16'h0001);
      repeat (2) @(posedge clk_sys);
      #1 {pc, pw} = {collision_activity_indicator_out, duplex_indicator_out};
      repeat (10 * BH) begin
         @(posedge clk_sys);
         #1 tc += (collision_activity_indicator_out != pc);
         td += (duplex_indicator_out != pw);
         {pc, pw} = {collision_activity_indicator_out, duplex_indicator_out};
      end
      `CHK(tc, 10)
      `CHK(td, 10)
   endtask
   // Power down darkens all lamps and releases again
   task automatic t_pd;
      @(posedge clk_sys);
      power_down_n <= 1'h0;
      repeat (5) @(posedge clk_sys);
      #1 `CHK(power_down, 1'h1)
      `CHK({speed_indicator_out, duplex_indicator_out, collision_activity_indicator_out}, 3'h7)
      // Status word: all levels high, blink bit left out as its phase is free
      rd(REG_STATUS);
      `CHK({got[15:8], got[6:0]}, 15'h007F)
      @(posedge clk_sys);
      power_down_n <= 1'h1;
      repeat (5) @(posedge clk_sys);
      #1 `CHK(power_down, 1'h0)
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Clock
   initial begin
      clk_sys = 1'h0;
      forever #50 clk_sys = ~clk_sys;
   end
   // Watchdog: a hang counts as a mismatch
   initial begin
      repeat (5000) @(posedge clk_sys);
      num_errors++;
      give_verdict;
   end
   // Main sequence
   initial begin
      {nrst, wr_en, rd_en, link_up, collision, activity} = 6'h00;
      {hundred_mbit_speed, full_duplex, power_down_n} = 3'h7;
      {addr, wr_data} = {5'h00, 16'h0000};
      {num_errors, checked} = 0;
      repeat (10) @(posedge clk_sys);
      nrst <= 1'h1;
      // No false power-down and no drive while the straps settle
      repeat (2) @(posedge clk_sys);
      #1 `CHK({power_down, speed_indicator_oe, duplex_indicator_oe, collision_activity_indicator_oe}, 4'h0)
      repeat (STRAP_CYCLES + 1) @(posedge clk_sys);
      #1 t_strap;
      t_modes;
      t_blink;
      t_pd;
      give_verdict;
   end
endmodule // psi_indicators_tb
